/* rtl/tcb_pkg.sv */
// tcb_pkg: register map, field positions and constants of the timer/counter
// assumes a 32-bit classic wishbone bus, byte addressed, register index in address bits 9:2
package tcb_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned RATE_W = 3;

	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_MODE = 8'hDA;
	localparam logic [7:0] IDX_COUNT = 8'hDB;
	localparam logic [7:0] IDX_RELOAD = 8'hCD;
	localparam logic [7:0] IDX_IRQ_CTRL = 8'hF0;
	localparam int unsigned IDX_LSB = 2;

	// mode register fields
	localparam int unsigned MODE_ENABLE = 7;
	localparam int unsigned MODE_RATE_HI = 6;
	localparam int unsigned MODE_RATE_LO = 4;
	localparam int unsigned MODE_CKS = 3;
	localparam int unsigned MODE_ALOAD = 2;
	localparam int unsigned MODE_TOGGLE = 1;
	localparam int unsigned MODE_PWM = 0;

	// interrupt control register fields
	localparam int unsigned IRQ_FLAG = 0;
	localparam int unsigned IRQ_ENABLE = 1;
	localparam int unsigned IRQ_LOW_POWER = 2;
	localparam int unsigned IRQ_CTRL_W = 3;

	localparam logic [CNT_W-1:0] MODE_RESET = 8'h00;
	localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
	localparam logic [CNT_W-1:0] RELOAD_RESET = 8'h00;
	localparam logic [CNT_W-1:0] FULL_SCALE = 8'hFF;
	localparam logic [CNT_W-1:0] ZERO_SCALE = 8'h00;

	// overflow boundaries in pwm mode on the prescaled clock, indexed by {auto_reload, toggle}
	localparam logic [CNT_W-1:0] TOP_256 = 8'hFF;
	localparam logic [CNT_W-1:0] TOP_64 = 8'h3F;
	localparam logic [CNT_W-1:0] TOP_32 = 8'h1F;
	localparam logic [CNT_W-1:0] TOP_16 = 8'h0F;

	localparam logic [7:0] IRQ_VECTOR = 8'h08;
endpackage : tcb_pkg

/* rtl/tcb_tick_gen.sv */
// tcb_tick_gen: selects the count tick, prescaled clock or external event edge
// assumes clk_i is the instruction clock; event_pin_i is asynchronous
`timescale 1ns/1ps
module tcb_tick_gen
	import tcb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clock_source_select_i,
	input wire logic [tcb_pkg::RATE_W-1:0] prescaler_select_i,
	input wire logic event_pin_i,
	output logic tick_o
);
	logic [CNT_W-1:0] div;
	logic [CNT_W-1:0] div_mask;
	logic sync_a;
	logic sync_b;
	logic sync_prev;

	// code 0 needs all eight bits full (divide by 256), code 7 only bit 0
	assign div_mask = FULL_SCALE >> prescaler_select_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div <= ZERO_SCALE;
		end else begin
			div <= div + 8'h01;
		end
	end

	// two-stage synchroniser; only the second stage feeds the edge detector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			sync_prev <= 1'b1;
		end else begin
			sync_a <= event_pin_i;
			sync_b <= sync_a;
			sync_prev <= sync_b;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else if (clock_source_select_i) begin
			tick_o <= sync_prev & ~sync_b;
		end else begin
			tick_o <= ((div & div_mask) == div_mask);
		end
	end
endmodule : tcb_tick_gen

/* rtl/tcb_timer.sv */
// tcb_timer: 8-bit timer/counter with auto-reload, toggle and pwm output
// assumes clk_i is the instruction clock; registers on classic wishbone
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module tcb_timer
	import tcb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tcb_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [tcb_pkg::DATA_W-1:0] wb_dat_i,
	output logic [tcb_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic external_event_pin_i,
	input wire logic gpio_data_i,
	input wire logic gpio_oe_n_i,
	output logic shared_output_pin_o,
	output logic shared_output_pin_oe_n_o,
	output logic irq_o,
	output logic [7:0] irq_vector_o,
	output logic ext_pin_irq_block_o
);
	import tcb_pkg::*;

	logic [CNT_W-1:0] mode;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] reload_buffer;
	logic [CNT_W-1:0] reload_active;
	logic overflow_request_flag;
	logic overflow_interrupt_enable;
	logic low_power_mode;
	logic toggle_level;
	logic pwm_level;
	logic tick;

	logic counter_enable_bit;
	logic clock_source_select;
	logic auto_reload_enable;
	logic toggle_output_enable;
	logic pwm_output_enable;
	logic pwm_internal;
	logic reload_on;
	logic [CNT_W-1:0] top_mask;
	logic at_top;
	logic ovf_evt;
	logic [CNT_W-1:0] count_inc;

	logic bus_req;
	logic bus_wr;
	logic [7:0] bus_idx;
	logic wr_mode;
	logic wr_count;
	logic wr_reload;
	logic wr_irq;

	assign counter_enable_bit = mode[MODE_ENABLE];
	assign clock_source_select = mode[MODE_CKS];
	assign auto_reload_enable = mode[MODE_ALOAD];
	assign toggle_output_enable = mode[MODE_TOGGLE];
	assign pwm_output_enable = mode[MODE_PWM];
	assign pwm_internal = pwm_output_enable & ~clock_source_select;

	// pwm always reloads; with pwm on the prescaled clock the auto-reload bit only helps select the boundary
	assign reload_on = pwm_output_enable | auto_reload_enable;

	always_comb begin
		top_mask = TOP_256;
		if (pwm_internal) begin
			case ({auto_reload_enable, toggle_output_enable})
				2'b00: top_mask = TOP_256;
				2'b01: top_mask = TOP_64;
				2'b10: top_mask = TOP_32;
				2'b11: top_mask = TOP_16;
				default: top_mask = TOP_256;
			endcase
		end
	end

	assign at_top = ((count & top_mask) == top_mask);
	assign count_inc = count + 8'h01;
	// a software write to the counter in the same cycle takes precedence
	assign ovf_evt = tick & counter_enable_bit & at_top & ~wr_count;

	// wishbone: ack one cycle after the request; write lands on the ack edge
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_idx = wb_adr_i[IDX_LSB +: 8];
	assign bus_wr = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
	assign wr_mode = bus_wr & (bus_idx == IDX_MODE);
	assign wr_count = bus_wr & (bus_idx == IDX_COUNT);
	assign wr_reload = bus_wr & (bus_idx == IDX_RELOAD);
	assign wr_irq = bus_wr & (bus_idx == IDX_IRQ_CTRL);

	tcb_tick_gen u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clock_source_select_i(clock_source_select),
		.prescaler_select_i(mode[MODE_RATE_HI:MODE_RATE_LO]),
		.event_pin_i(external_event_pin_i),
		.tick_o(tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			wb_dat_o <= '0;
			if (bus_req & ~wb_ack_o & ~wb_we_i) begin
				case (bus_idx)
					IDX_MODE: wb_dat_o[CNT_W-1:0] <= mode;
					IDX_COUNT: wb_dat_o[CNT_W-1:0] <= count;
					IDX_IRQ_CTRL: wb_dat_o[IRQ_CTRL_W-1:0] <=
						{low_power_mode, overflow_interrupt_enable, overflow_request_flag};
					// reload buffer is write-only; unmapped reads return zero
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= MODE_RESET;
		end else if (wr_mode) begin
			mode <= wb_dat_i[CNT_W-1:0];
		end
	end

	// are left to software; a mid-run mode write acts at once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= COUNT_RESET;
		end else if (wr_count) begin
			count <= wb_dat_i[CNT_W-1:0];
		end else if (tick & counter_enable_bit) begin
			if (at_top) begin
				if (pwm_output_enable) begin
					count <= ZERO_SCALE;
				end else if (reload_on) begin
					count <= reload_buffer;
				end else begin
					count <= ZERO_SCALE;
				end
			end else begin
				count <= count + 8'h01;
			end
		end
	end

	// double buffer: the running cycle keeps its value until overflow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reload_buffer <= RELOAD_RESET;
			reload_active <= RELOAD_RESET;
		end else begin
			if (wr_reload) begin
				reload_buffer <= wb_dat_i[CNT_W-1:0];
			end
			if (ovf_evt & reload_on) begin
				reload_active <= reload_buffer;
			end
		end
	end

	// low-power bit is kept for software only: overflow never wakes the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_request_flag <= 1'b0;
			overflow_interrupt_enable <= 1'b0;
			low_power_mode <= 1'b0;
		end else begin
			if (wr_irq) begin
				overflow_interrupt_enable <= wb_dat_i[IRQ_ENABLE];
				low_power_mode <= wb_dat_i[IRQ_LOW_POWER];
			end
			if (ovf_evt) begin
				overflow_request_flag <= 1'b1;
			end else if (wr_irq & ~wb_dat_i[IRQ_FLAG]) begin
				overflow_request_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			irq_vector_o <= IRQ_VECTOR;
			ext_pin_irq_block_o <= 1'b0;
		end else begin
			irq_o <= overflow_request_flag & overflow_interrupt_enable;
			irq_vector_o <= IRQ_VECTOR;
			ext_pin_irq_block_o <= clock_source_select;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			toggle_level <= 1'b0;
		end else if (ovf_evt) begin
			toggle_level <= ~toggle_level;
		end
	end

	// pwm: high after overflow, low once the masked count meets the duty
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_level <= 1'b1;
		end else if (~counter_enable_bit | ovf_evt) begin
			pwm_level <= 1'b1;
		end else if (tick & ~wr_count & ~at_top
			& ((count_inc & top_mask) == (reload_active & top_mask))) begin
			// fall on the edge of the step, so the high time is exactly the duty in ticks
			pwm_level <= 1'b0;
		end else if ((count & top_mask) == (reload_active & top_mask)) begin
			pwm_level <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shared_output_pin_o <= 1'b0;
			shared_output_pin_oe_n_o <= 1'b1;
		end else if (pwm_output_enable) begin
			shared_output_pin_o <= pwm_level;
			shared_output_pin_oe_n_o <= 1'b0;
		end else if (toggle_output_enable) begin
			shared_output_pin_o <= toggle_level;
			shared_output_pin_oe_n_o <= 1'b0;
		end else begin
			shared_output_pin_o <= gpio_data_i;
			shared_output_pin_oe_n_o <= gpio_oe_n_i;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence ovf_then_toggle_s;
		ovf_evt & ~pwm_output_enable & toggle_output_enable ##1 toggle_output_enable;
	endsequence

	// a running pwm cycle with no software write that could move count or boundary
	sequence pwm_run_s;
		pwm_output_enable & counter_enable_bit & ~ovf_evt & ~wr_count & ~wr_mode;
	endsequence

	stop_hold_a: assert property (~counter_enable_bit & ~wr_count |=> $stable(count))
		else $error("counter moved while disabled");
	count_step_a: assert property (tick & counter_enable_bit & ~at_top & ~wr_count
		|=> count == $past(count) + 8'h01)
		else $error("counter did not step by one");
	flag_set_a: assert property (ovf_evt |=> overflow_request_flag)
		else $error("overflow flag not set");
	irq_out_a: assert property (overflow_request_flag & overflow_interrupt_enable
		|=> irq_o && irq_vector_o == IRQ_VECTOR)
		else $error("interrupt not raised");
	reload_load_a: assert property (ovf_evt & ~pwm_output_enable & auto_reload_enable
		|=> count == $past(reload_buffer))
		else $error("reload value not loaded");
	no_reload_a: assert property (ovf_evt & ~pwm_output_enable & ~auto_reload_enable
		|=> count == ZERO_SCALE)
		else $error("counter not wrapped to zero");
	ext_block_a: assert property (clock_source_select |=> ext_pin_irq_block_o)
		else $error("external pin irq not suppressed");
	pwm_top_a: assert property (pwm_internal & {auto_reload_enable, toggle_output_enable} == 2'b11
		|-> top_mask == TOP_16)
		else $error("pwm boundary wrong");
	toggle_pin_a: assert property (ovf_then_toggle_s
		|=> shared_output_pin_o == ~$past(toggle_level, 2))
		else $error("toggle pin did not flip");
	pwm_high_a: assert property (ovf_evt & pwm_output_enable ##1 pwm_output_enable
		|=> shared_output_pin_o && !shared_output_pin_oe_n_o)
		else $error("pwm not high after overflow");
	pwm_low_a: assert property (pwm_run_s ##1 (count & top_mask) == (reload_active & top_mask)
		|-> ~pwm_level)
		else $error("pwm not low at duty match");
	flag_hold_a: assert property (overflow_request_flag & ~(wr_irq & ~wb_dat_i[IRQ_FLAG])
		|=> overflow_request_flag)
		else $error("overflow flag lost");
	ext_clear_a: assert property (~clock_source_select |=> ~ext_pin_irq_block_o)
		else $error("external pin irq blocked in timer mode");
	pin_gpio_a: assert property (~pwm_output_enable & ~toggle_output_enable
		|=> shared_output_pin_oe_n_o == $past(gpio_oe_n_i) && shared_output_pin_o == $past(gpio_data_i))
		else $error("pin not handed back to port logic");
endmodule : tcb_timer

/* dv/tcb_pin_model.sv */
// tcb_pin_model: far side of the timer pins, an event source on the input pin
// assumes the bench calls pulses() from one thread; the pin idles high (pull-up)
`timescale 1ns/1ps
module tcb_pin_model (
	input wire logic clk_i,
	output logic event_pin_o
);
	initial begin
		event_pin_o = 1'b1;
	end

	// levels change just after a rising edge; the synchroniser still adds its two stages
	task automatic pulses(input int n, input int half);
		repeat (n) begin
			@(posedge clk_i);
			event_pin_o <= 1'b0;
			repeat (half) @(posedge clk_i);
			event_pin_o <= 1'b1;
			repeat (half) @(posedge clk_i);
		end
	endtask : pulses
endmodule : tcb_pin_model

/* dv/tb.sv */
// tb: self-checking bench for the timer, wishbone master plus pin model
// assumes 100 MHz clock and the register indexes of tcb_pkg
`timescale 1ns/1ps
module tb;
	import tcb_pkg::*;
	typedef struct {logic [7:0] mode; logic [7:0] rld; int per; int hi;} tcb_row_s;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic gdat = 0;
	logic goe_n = 1;
	logic [9:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] dat = '0;
	logic [31:0] dat_o;
	logic [31:0] q;
	logic ack, pin, pin_oe_n, irq, blk, ev;
	logic [7:0] vec;
	int n_errors = 0;
	int checks = 0;
	int hi, lo, t;
	// toggle rows for every rate, toggle without reload, then pwm resolutions
	tcb_row_s rows [13] = '{'{8'h86, 8'hFE, 1024, 512}, '{8'h96, 8'hFE, 512, 256},
		'{8'hA6, 8'hFE, 256, 128}, '{8'hB6, 8'hFE, 128, 64}, '{8'hC6, 8'hFE, 64, 32},
		'{8'hD6, 8'hFE, 32, 16}, '{8'hE6, 8'hFE, 16, 8}, '{8'hF6, 8'hFE, 8, 4},
		'{8'hF2, 8'hFE, 1024, 512}, '{8'hF1, 8'h01, 512, 2}, '{8'hF3, 8'h01, 128, 2},
		'{8'hF5, 8'h01, 64, 2}, '{8'hF7, 8'h01, 32, 2}};

	always #5 clk_i = ~clk_i;

	tcb_timer i_tcb_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .external_event_pin_i(ev), .gpio_data_i(gdat), .gpio_oe_n_i(goe_n),
		.shared_output_pin_o(pin), .shared_output_pin_oe_n_o(pin_oe_n), .irq_o(irq),
		.irq_vector_o(vec), .ext_pin_irq_block_o(blk));
	tcb_pin_model i_tcb_pin_model (.clk_i(clk_i), .event_pin_o(ev));

	task automatic stop_test;
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// single classic cycle; read data lands in q at the ack edge; a lost ack is left to the watchdog
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= {idx, 2'b00};
		dat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("wb ack", 2, n);
	endtask : wb

	// mode bits first with enable low, then equal count and reload, then enable
	task automatic cfg(input logic [7:0] mode, input logic [7:0] rld);
		wb(1, IDX_MODE, mode & 8'h7F);
		wb(1, IDX_COUNT, rld);
		wb(1, IDX_RELOAD, rld);
		wb(1, IDX_MODE, mode);
	endtask : cfg

	task automatic wait_lvl(input logic v, output int c);
		c = 0;
		while (pin !== v) begin
			@(posedge clk_i);
			c++;
			if (c > 3000) begin
				n_errors++;
				stop_test;
			end
		end
	endtask : wait_lvl

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("vector", 8'h08, vec);
		chk("oe_n reset", 1, pin_oe_n);
		chk("block reset", 0, blk);
		wb(0, IDX_MODE, 0);
		chk("mode reset", 0, q);
		wb(0, IDX_COUNT, 0);
		chk("count reset", 0, q);
		wb(0, IDX_RELOAD, 0);
		chk("reload read", 0, q);
		wb(0, 8'h01, 0);
		chk("unmapped", 0, q);
		wb(1, IDX_MODE, 8'h5A);
		wb(0, IDX_MODE, 0);
		chk("mode rw", 8'h5A, q);
		foreach (rows[i]) begin
			cfg(rows[i].mode, rows[i].rld);
			wait_lvl(0, t);
			wait_lvl(1, t);
			wait_lvl(0, hi);
			wait_lvl(1, lo);
			chk("period", rows[i].per, hi + lo);
			chk("high time", rows[i].hi, hi);
			chk("oe_n drive", 0, pin_oe_n);
		end
		wb(1, IDX_MODE, 8'h80);
		gdat <= 1'b1;
		goe_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("gpio pin", 1, pin);
		chk("gpio oe_n", 0, pin_oe_n);
		cfg(8'h8C, 8'hFD);
		wb(1, IDX_IRQ_CTRL, 8'h06);
		repeat (600) @(posedge clk_i);
		wb(0, IDX_COUNT, 0);
		chk("event idle", 8'hFD, q);
		chk("pin irq block", 1, blk);
		i_tcb_pin_model.pulses(2, 20);
		repeat (8) @(posedge clk_i);
		wb(0, IDX_COUNT, 0);
		chk("event count", 8'hFF, q);
		chk("irq early", 0, irq);
		i_tcb_pin_model.pulses(1, 3);
		repeat (8) @(posedge clk_i);
		chk("irq", 1, irq);
		wb(0, IDX_COUNT, 0);
		chk("reloaded", 8'hFD, q);
		wb(1, IDX_IRQ_CTRL, 8'h07);
		wb(0, IDX_IRQ_CTRL, 0);
		chk("flag held", 1, q[IRQ_FLAG]);
		wb(1, IDX_IRQ_CTRL, 8'h02);
		wb(0, IDX_IRQ_CTRL, 0);
		chk("flag clear", 0, q[IRQ_FLAG]);
		chk("irq clear", 0, irq);
		wb(1, IDX_MODE, 8'h0C);
		i_tcb_pin_model.pulses(2, 3);
		repeat (8) @(posedge clk_i);
		wb(0, IDX_COUNT, 0);
		chk("stopped", 8'hFD, q);
		cfg(8'hF4, 8'hF0);
		wb(1, IDX_RELOAD, 8'h10);
		wb(0, IDX_COUNT, 0);
		chk("running count", 4'hF, q[7:4]);
		repeat (40) @(posedge clk_i);
		wb(0, IDX_COUNT, 0);
		chk("new interval", 4'h1, q[7:4]);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("pin rerun", 0, pin);
		chk("oe_n rerun", 1, pin_oe_n);
		chk("irq rerun", 0, irq);
		wb(0, IDX_MODE, 0);
		chk("mode rerun", 0, q);
		wb(0, IDX_COUNT, 0);
		chk("count rerun", 0, q);
		stop_test;
	end

	initial begin
		#600000;
		n_errors++;
		stop_test;
	end
endmodule : tb
